/* File: verification/dmaes_ahb_host.sv */
// AHB-Lite master model standing in for the processor side of the block.
// Assumes hready is the slave's own ready, fed back by the bench.
`timescale 1ns/1ps
`default_nettype none
module dmaes_ahb_host (
    input wire logic clk_i,
    input wire logic [31:0] hrdata_i,
    input wire logic hreadyout_i,
    input wire logic hresp_i,
    output logic hsel_o,
    output logic [31:0] haddr_o,
    output logic [1:0] htrans_o,
    output logic hwrite_o,
    output logic [2:0] hsize_o,
    output logic [31:0] hwdata_o
);
    // ****************************************
    // Single transfers
    // ****************************************
    initial
    begin
        hsel_o = 1'b0;
        haddr_o = 32'hffff_ffff;
        htrans_o = 2'h0;
        hwrite_o = 1'b0;
        hsize_o = 3'h2;
        hwdata_o = 32'h0000_0000;
    end

    // Called at a rising edge. Released address and write data carry inverted values, so a
    // slave that samples them late sees garbage rather than a stale match.
    task automatic xfer(input logic [31:0] a, input logic wr, input logic [2:0] sz,
            input logic [31:0] wd, output logic [31:0] rd, output logic rsp);
        int n;
        n = 0;
        hsel_o <= 1'b1;
        haddr_o <= a;
        htrans_o <= 2'h2;
        hwrite_o <= wr;
        hsize_o <= sz;
        @(posedge clk_i);
        hsel_o <= 1'b0;
        haddr_o <= ~a;
        htrans_o <= 2'h0;
        hwdata_o <= wd;
        // The answer is read at the falling edge, where it stands settled for
        // the rising edge that ends the data phase; reading at that rising
        // edge itself would race the slave's registers.
        @(negedge clk_i);
        while (hreadyout_i !== 1'b1 && n < 8)
        begin
            @(negedge clk_i);
            n++;
        end
        rd = hrdata_i;
        rsp = hresp_i;
        @(posedge clk_i);
        hwdata_o <= ~wd;
    endtask : xfer
endmodule : dmaes_ahb_host
`default_nettype wire

/* File: verification/dmaes_top_bench.sv */
// Self-checking bench for the DMA event, error and status block.
// Assumes the host model of dmaes_ahb_host.sv drives the register bus.
`timescale 1ns/1ps
`default_nettype none
module dmaes_top_bench;
    localparam int NCH = dmaes_pkg::NUM_CH;
    localparam logic [31:0] LO = 32'h5000_0000;
    localparam logic [31:0] HI = 32'h9fff_ffff;
    localparam logic [31:0] STS_ADDR = dmaes_pkg::BASE_ADDR + 32'(dmaes_pkg::STATUS_OFS);
    localparam logic [31:0] CLR_ADDR = dmaes_pkg::BASE_ADDR + 32'(dmaes_pkg::CLEAR_OFS);
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic hsel, hwrite, hready, hresp, rsp;
    logic [31:0] haddr, hwdata, hrdata, exp_v, rdv;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [NCH-1:0] acc_v = '0, half_ev = '0, done_ev = '0, en_clr, irq, creq;
    logic [NCH-1:0] half_en = 6'h15, done_en = 6'h2a, err_en = 6'h2a, adc_sel = '0;
    logic [NCH*32-1:0] acc_a = '0;
    logic [NCH*3-1:0] psel = '0;
    logic [7:0] preq = 8'h5a;
    logic adc_req = 1'b0;
    int n_errors = 0, total_checks = 0, cycles = 0;

    always #10 clk_i = ~clk_i;

    dmaes_ahb_host host_u (.clk_i(clk_i), .hrdata_i(hrdata), .hreadyout_i(hready),
        .hresp_i(hresp), .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans),
        .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));

    dmaes_top #(.RSVD_LO(LO), .RSVD_HI(HI)) dut_u (.clk_i(clk_i), .rstn_i(rstn_i),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
        .hreadyout_o(hready), .hresp_o(hresp), .chan_acc_valid_i(acc_v),
        .chan_acc_addr_i(acc_a), .half_done_event_i(half_ev), .xfer_done_event_i(done_ev),
        .half_done_irq_en_i(half_en), .xfer_done_irq_en_i(done_en),
        .xfer_error_irq_en_i(err_en), .periph_req_i(preq), .adc_req_i(adc_req),
        .adc_sel_i(adc_sel), .periph_sel_i(psel), .chan_req_o(creq),
        .chan_en_clr_o(en_clr), .chan_irq_o(irq));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask : check

    task automatic reg_acc(input logic [31:0] a, input logic wr, input logic [2:0] sz,
            input logic [31:0] wd, input logic [31:0] ed, input logic er);
        @(posedge clk_i);
        host_u.xfer(a, wr, sz, wd, rdv, rsp);
        check("bus response", 32'(er), 32'(rsp));
        if (!wr)
            check("read data", ed, rdv);
    endtask : reg_acc

    // Kind 1 is done, 2 is half, 3 is a channel access at address a.
    task automatic fire(input int c, input int k, input logic [31:0] a);
        @(posedge clk_i);
        done_ev[c] <= (k == 1);
        half_ev[c] <= (k == 2);
        acc_v[c] <= (k == 3);
        acc_a[c*32 +: 32] <= a;
        @(posedge clk_i);
        done_ev <= '0;
        half_ev <= '0;
        acc_v <= '0;
        acc_a[c*32 +: 32] <= ~a;
        #1;
    endtask : fire

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results

    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            n_errors = n_errors + 1;
            results();
        end
    end

    initial
    begin
        repeat (12) @(posedge clk_i);
        rstn_i <= 1'b1;
        reg_acc(STS_ADDR, 1'b0, 3'h2, 32'h0, 32'h0, 1'b0);
        reg_acc(CLR_ADDR, 1'b0, 3'h2, 32'h0, 32'h0, 1'b0);
        $display("reset values done");
        fire(0, 3, LO - 32'h1);
        fire(1, 3, HI + 32'h1);
        check("enable clear", 32'h0, 32'(en_clr));
        reg_acc(STS_ADDR, 1'b0, 3'h2, 32'h0, 32'h0, 1'b0);
        for (int c = 0; c < NCH; c++)
        begin
            for (int k = 1; k < 4; k++)
            begin
                fire(c, k, c[0] ? LO : HI);
                check("enable clear", (k == 3) ? 32'h1 << c : 32'h0, 32'(en_clr));
                @(posedge clk_i);
                #1;
                check("enable clear", 32'h0, 32'(en_clr));
                exp_v = (k == 2) ? 32'(half_en) : (k == 1) ? 32'(done_en) : 32'(err_en);
                check("interrupt", exp_v & (32'h1 << c), 32'(irq));
                exp_v = (32'h1 | (32'h1 << k)) << (4 * c);
                reg_acc(STS_ADDR, 1'b0, 3'h2, 32'h0, exp_v, 1'b0);
                reg_acc(CLR_ADDR, 1'b1, 3'h2, 32'h1 << (4 * c + k), 32'h0, 1'b0);
                reg_acc(STS_ADDR, 1'b0, 3'h2, 32'h0, 32'h1 << (4 * c), 1'b0);
                reg_acc(CLR_ADDR, 1'b1, 3'h2, 32'h1 << (4 * c), 32'h0, 1'b0);
                reg_acc(STS_ADDR, 1'b0, 3'h2, 32'h0, 32'h0, 1'b0);
            end
        end
        $display("event flags done");
        fire(2, 1, 32'h0);
        reg_acc(CLR_ADDR, 1'b1, 3'h0, 32'hffff_ffff, 32'h0, 1'b1);
        reg_acc(CLR_ADDR, 1'b1, 3'h1, 32'hffff_ffff, 32'h0, 1'b1);
        reg_acc(STS_ADDR, 1'b1, 3'h2, 32'hffff_ffff, 32'h0, 1'b0);
        reg_acc(STS_ADDR, 1'b0, 3'h2, 32'h0, 32'h0000_0300, 1'b0);
        reg_acc(CLR_ADDR, 1'b1, 3'h2, 32'hffff_ffff, 32'h0, 1'b0);
        reg_acc(STS_ADDR, 1'b0, 3'h2, 32'h0, 32'h0, 1'b0);
        $display("refused access done");
        fire(4, 2, 32'h0);
        @(posedge clk_i);
        #1;
        check("interrupt", 32'h10, 32'(irq));
        @(posedge clk_i);
        rstn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        #1;
        check("interrupt", 32'h0, 32'(irq));
        reg_acc(STS_ADDR, 1'b0, 3'h2, 32'h0, 32'h0, 1'b0);
        $display("mid-run reset done");
        for (int p = 0; p < 8; p++)
        begin
            @(posedge clk_i);
            psel <= {NCH{3'(p)}};
            adc_req <= p[0];
            adc_sel <= 6'h0f;
            @(posedge clk_i);
            #1;
            check("request", {26'h0, preq[p], preq[p], {4{p[0]}}}, 32'(creq));
        end
        $display("request mapping done");
        results();
    end
endmodule : dmaes_top_bench
`default_nettype wire

/* File: verilog/dmaes_flag.sv */
// One sticky event flag, set by hardware and cleared by a write of one.
// Assumes set and clear are single-cycle strobes on clk_i.
`timescale 1ns/1ps
`default_nettype none
module dmaes_flag (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic set_i,
    input wire logic clr_i,
    output logic flag_o
);

    logic flag_q;
    logic flag_d;

    // A set in the same cycle as a clear wins so that no event is lost.
    assign flag_d = set_i | (flag_q & ~clr_i);

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            flag_q <= dmaes_pkg::FLAG_RESET;
        end
        else
        begin
            flag_q <= flag_d;
        end
    end

    assign flag_o = flag_q;

    a_set_beats_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
        set_i |=> flag_q)
        else $error("flag lost an event that arrived with a clear");

endmodule : dmaes_flag
`default_nettype wire

/* File: verilog/dmaes_pkg.sv */
// Package with the register map, flag layout and bus encodings of the DMA
// event, error and status block.
// Assumes a 32-bit AHB-Lite system bus and at most eight DMA channels.
`default_nettype none
package dmaes_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [31:0] BASE_ADDR = 32'ha000_0000;
    localparam int OFS_W = 8;
    localparam logic [7:0] STATUS_OFS = 8'h00;
    localparam logic [7:0] CLEAR_OFS = 8'h04;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] CLEAR_RESET = 32'h0000_0000;

    // ************************************************************
    // Flag layout inside one channel nibble
    // ************************************************************
    localparam int BITS_PER_CH = 4;
    localparam int SUMMARY_POS = 0;
    localparam int DONE_POS = 1;
    localparam int HALF_POS = 2;
    localparam int ERROR_POS = 3;
    localparam logic FLAG_RESET = 1'b0;

    // ************************************************************
    // Channel and request counts
    // ************************************************************
    localparam int NUM_CH = 6;
    localparam int NUM_PERIPH_REQ = 8;
    localparam int PSEL_W = 3;

    // ************************************************************
    // AHB encodings
    // ************************************************************
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // Bus answer sequencer; the two error states form the two-cycle ERROR response.
    typedef enum logic [1:0] {
        RSP_OKAY = 2'b00,
        RSP_ERR1 = 2'b01,
        RSP_ERR2 = 2'b10
    } dmaes_rsp_t;

endpackage : dmaes_pkg
`default_nettype wire

/* File: verilog/dmaes_top.sv */
// DMA event, error and interrupt status block with its AHB-Lite register slave.
// Assumes the transfer engine reports half and full completion as one-cycle pulses
// and presents each channel bus access with its address, all on clk_i.
// Functional notes
// - A channel access whose address falls in the reserved region is a transfer error.
// - A transfer error pulses the channel enable clear so the engine stops that channel.
// - A transfer error sets the error flag whatever its enable, and interrupts only when its enable is set.
// - Half, done and error flags each raise the channel interrupt under their own enable.
// - Each channel request is a chosen peripheral request or the ADC request.
// - The read-only status register sits at offset 0x00 of base 0xA0000000.
// - The write-only clear register sits at offset 0x04 and resets to zero.
// - Channel n holds summary at bit 4n, done at 4n+1, half at 4n+2, error at 4n+3.
// - The summary flag sets on any error, half or done event of its channel.
// - Only hardware sets flags and software clears one by writing 1 at its position.
// - Every status flag resets to zero.
// - The nibble pattern runs through channel 5 whose error flag is bit 23.
`timescale 1ns/1ps
`default_nettype none
module dmaes_top #(
    parameter int NUM_CH = dmaes_pkg::NUM_CH,
    parameter int NUM_PERIPH_REQ = dmaes_pkg::NUM_PERIPH_REQ,
    parameter logic [31:0] RSVD_LO = 32'h5000_0000,
    parameter logic [31:0] RSVD_HI = 32'h9fff_ffff
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic [NUM_CH-1:0] chan_acc_valid_i,
    input wire logic [NUM_CH*32-1:0] chan_acc_addr_i,
    input wire logic [NUM_CH-1:0] half_done_event_i,
    input wire logic [NUM_CH-1:0] xfer_done_event_i,
    input wire logic [NUM_CH-1:0] half_done_irq_en_i,
    input wire logic [NUM_CH-1:0] xfer_done_irq_en_i,
    input wire logic [NUM_CH-1:0] xfer_error_irq_en_i,
    input wire logic [NUM_PERIPH_REQ-1:0] periph_req_i,
    input wire logic adc_req_i,
    input wire logic [NUM_CH-1:0] adc_sel_i,
    input wire logic [NUM_CH*dmaes_pkg::PSEL_W-1:0] periph_sel_i,
    output logic [NUM_CH-1:0] chan_req_o,
    output logic [NUM_CH-1:0] chan_en_clr_o,
    output logic [NUM_CH-1:0] chan_irq_o
);

    localparam int FW = NUM_CH * dmaes_pkg::BITS_PER_CH;

    // ************************************************************
    // Bus address phase decode
    // ************************************************************
    wire logic addr_phase;
    wire logic size_ok;
    wire logic [7:0] reg_ofs;
    wire logic bad_acc;
    wire logic rd_status;
    wire logic wr_clear;

    assign addr_phase = hsel_i & htrans_i[1] & hready_i;
    assign size_ok = (hsize_i == dmaes_pkg::HSIZE_WORD);
    assign reg_ofs = haddr_i[dmaes_pkg::OFS_W-1:0];
    // Narrow accesses are answered with ERROR, which the core turns into a fault.
    assign bad_acc = addr_phase & ~size_ok;
    assign rd_status = addr_phase & size_ok & ~hwrite_i & (reg_ofs == dmaes_pkg::STATUS_OFS);
    assign wr_clear = addr_phase & size_ok & hwrite_i & (reg_ofs == dmaes_pkg::CLEAR_OFS);

    logic clr_pend_q;
    wire logic [31:0] clr_vec;

    // Write data arrives in the data phase, one cycle after the address was taken.
    assign clr_vec = clr_pend_q ? hwdata_i : dmaes_pkg::CLEAR_RESET;

    // ************************************************************
    // Per-channel flags, errors and requests
    // ************************************************************
    wire logic [31:0] status_w;
    wire logic [NUM_CH-1:0] err_ev;
    wire logic [NUM_CH-1:0] any_ev;
    wire logic [NUM_CH-1:0] irq_d;
    wire logic [NUM_CH-1:0] req_d;
    logic [NUM_CH-1:0] irq_q;
    logic [NUM_CH-1:0] en_clr_q;
    logic [NUM_CH-1:0] req_q;

    // Every check in this module runs on the system clock and sleeps in reset.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    genvar c;
    genvar k;
    generate
        for (c = 0; c < NUM_CH; c++)
        begin : g_ch
            wire logic [31:0] acc_addr;
            wire logic [dmaes_pkg::PSEL_W-1:0] psel;
            wire logic [dmaes_pkg::BITS_PER_CH-1:0] ev;
            wire logic [dmaes_pkg::BITS_PER_CH-1:0] fl;

            assign acc_addr = chan_acc_addr_i[c*32 +: 32];
            // One contiguous reserved window is decoded; a split map needs a second compare.
            assign err_ev[c] = chan_acc_valid_i[c] & (acc_addr >= RSVD_LO)
                               & (acc_addr <= RSVD_HI);
            assign any_ev[c] = err_ev[c] | half_done_event_i[c] | xfer_done_event_i[c];
            assign ev[dmaes_pkg::SUMMARY_POS] = any_ev[c];
            assign ev[dmaes_pkg::DONE_POS] = xfer_done_event_i[c];
            assign ev[dmaes_pkg::HALF_POS] = half_done_event_i[c];
            assign ev[dmaes_pkg::ERROR_POS] = err_ev[c];

            for (k = 0; k < dmaes_pkg::BITS_PER_CH; k++)
            begin : g_bit
                dmaes_flag u_flag (
                    .clk_i(clk_i),
                    .rstn_i(rstn_i),
                    .set_i(ev[k]),
                    .clr_i(clr_vec[c*dmaes_pkg::BITS_PER_CH + k]),
                    .flag_o(fl[k])
                );
                a_clear_drops_flag: assert property (
                    (clr_vec[c*dmaes_pkg::BITS_PER_CH + k] && !ev[k]) |=> !fl[k])
                    else $error("a written clear bit left its flag set");
            end

            // Channel nibbles pack upward from bit 0.
            assign status_w[c*dmaes_pkg::BITS_PER_CH +: dmaes_pkg::BITS_PER_CH] = fl;
            assign irq_d[c] = (fl[dmaes_pkg::DONE_POS] & xfer_done_irq_en_i[c])
                              | (fl[dmaes_pkg::HALF_POS] & half_done_irq_en_i[c])
                              | (fl[dmaes_pkg::ERROR_POS] & xfer_error_irq_en_i[c]);
            assign psel = periph_sel_i[c*dmaes_pkg::PSEL_W +: dmaes_pkg::PSEL_W];
            assign req_d[c] = adc_sel_i[c] ? adc_req_i : periph_req_i[psel];

            a_error_stops_chan: assert property (
                err_ev[c] |=> chan_en_clr_o[c] && status_w[c*4 + dmaes_pkg::ERROR_POS])
                else $error("error did not stop the channel and set its flag");
            a_summary_on_event: assert property (
                (half_done_event_i[c] || xfer_done_event_i[c])
                |=> status_w[c*4 + dmaes_pkg::SUMMARY_POS])
                else $error("summary flag missed a channel event");
            a_error_irq_gated: assert property (
                (err_ev[c] && xfer_error_irq_en_i[c]) ##1 xfer_error_irq_en_i[c] |=> chan_irq_o[c])
                else $error("enabled transfer error raised no interrupt");
            a_done_sets_flag: assert property (
                xfer_done_event_i[c] |=> status_w[c*4 + dmaes_pkg::DONE_POS])
                else $error("transfer complete did not set its flag");
        end
        if (FW < 32)
        begin : g_pad
            assign status_w[31:FW] = '0;
        end
    endgenerate

    // ************************************************************
    // Bus answer sequencer
    // ************************************************************
    dmaes_pkg::dmaes_rsp_t rsp_q;
    dmaes_pkg::dmaes_rsp_t rsp_d;
    logic hreadyout_q;
    logic hreadyout_d;
    logic hresp_q;
    logic hresp_d;
    logic [31:0] hrdata_q;
    wire logic [31:0] hrdata_d;

    // Status is sampled at the address phase so the data phase needs no wait state.
    assign hrdata_d = rd_status ? status_w : 32'h0000_0000;

    always_comb
    begin
        rsp_d = dmaes_pkg::RSP_OKAY;
        hreadyout_d = 1'b1;
        hresp_d = 1'b0;
        unique case (rsp_q)
            dmaes_pkg::RSP_OKAY, dmaes_pkg::RSP_ERR2:
            begin
                if (bad_acc)
                begin
                    rsp_d = dmaes_pkg::RSP_ERR1;
                    hreadyout_d = 1'b0;
                    hresp_d = 1'b1;
                end
            end
            dmaes_pkg::RSP_ERR1:
            begin
                rsp_d = dmaes_pkg::RSP_ERR2;
                hresp_d = 1'b1;
            end
            default:
            begin
                rsp_d = dmaes_pkg::RSP_OKAY;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rsp_q <= dmaes_pkg::RSP_OKAY;
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
            hrdata_q <= dmaes_pkg::STATUS_RESET;
            clr_pend_q <= 1'b0;
        end
        else
        begin
            rsp_q <= rsp_d;
            hreadyout_q <= hreadyout_d;
            hresp_q <= hresp_d;
            hrdata_q <= hrdata_d;
            clr_pend_q <= wr_clear;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            irq_q <= '0;
            en_clr_q <= '0;
            req_q <= '0;
        end
        else
        begin
            irq_q <= irq_d;
            en_clr_q <= err_ev;
            req_q <= req_d;
        end
    end

    assign hrdata_o = hrdata_q;
    assign hreadyout_o = hreadyout_q;
    assign hresp_o = hresp_q;
    assign chan_irq_o = irq_q;
    assign chan_en_clr_o = en_clr_q;
    assign chan_req_o = req_q;

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_narrow_access;
        bad_acc && (rsp_q != dmaes_pkg::RSP_ERR1);
    endsequence

    sequence s_error_answer;
        (!hreadyout_o && hresp_o) ##1 (hreadyout_o && hresp_o);
    endsequence

    sequence s_clear_write;
        wr_clear ##1 (clr_pend_q && hwdata_i == 32'hffff_ffff && any_ev == '0);
    endsequence

    a_narrow_faults: assert property (
        s_narrow_access |=> s_error_answer)
        else $error("narrow access did not get a two-cycle error answer");

    a_read_status: assert property (
        rd_status |=> hrdata_o == $past(status_w))
        else $error("status read returned wrong data");

    a_clear_reads_zero: assert property (
        (addr_phase && size_ok && !hwrite_i && reg_ofs == dmaes_pkg::CLEAR_OFS)
        |=> hrdata_o == 32'h0000_0000)
        else $error("clear register read was not zero");

    a_clear_all_flags: assert property (
        s_clear_write |=> status_w == 32'h0000_0000)
        else $error("writing ones did not clear every flag");

    a_zero_keeps_flags: assert property (
        (clr_vec == 32'h0000_0000 && any_ev == '0) |=> $stable(status_w))
        else $error("flags changed without event or clear");

    a_unused_bits_zero: assert property (
        (status_w >> FW) == 32'h0000_0000)
        else $error("status bits above the last channel are not zero");

    a_irq_has_cause: assert property (
        (chan_irq_o != '0) |-> $past(irq_d != '0))
        else $error("interrupt without an enabled flag");

    a_req_follows_mux: assert property (
        ##1 chan_req_o[0] == $past(adc_sel_i[0] ? adc_req_i : periph_req_i[periph_sel_i[2:0]]))
        else $error("channel 0 request does not follow its selection");

    a_en_clr_pulse: assert property (
        (chan_en_clr_o != '0) |-> (chan_en_clr_o == $past(err_ev)))
        else $error("enable clear is not a one-cycle pulse of the error");

    a_word_okay: assert property (
        (addr_phase && size_ok) |=> (hreadyout_o && !hresp_o))
        else $error("word access did not get a zero-wait okay answer");

    a_narrow_no_clear: assert property (
        bad_acc |=> !clr_pend_q)
        else $error("narrow access reached the flag clear");

endmodule : dmaes_top
`default_nettype wire
